// *** tsc_cfg.svh ***
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH
`define TSC_CTRL_ADDR 8'h13
`define TSC_CTRL_RESET 8'h00
`define TSC_BIT_EVENT_RESET 5
`define TSC_BIT_HOT_RESET 4
`define TSC_BIT_COLD_RESET 3
`define TSC_BIT_EVENT_OW 2
`define TSC_BIT_HOT_OW 1
`define TSC_BIT_COLD_OW 0
`define TSC_OW_RESET 3'h0
`define TSC_STAMP_CLEAR_VALUE 8'h00
`endif

// *** tsc_pkg.sv ***
`default_nettype none
package tsc_pkg;
   // Register-side request from the serial bus engine
   typedef struct packed {
      logic rdEn;
      logic wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } tsc_req_t;

   // Overwrite selects, one per stamp group
   typedef struct packed {
      logic eventOw;
      logic hotOw;
      logic coldOw;
   } tsc_ow_t;

   typedef struct packed {
      tsc_ow_t ow;
      logic [7:0] rdData;
      logic rdValid;
   } tsc_state_t;

   typedef struct packed {
      logic pulse;
   } tsc_clear_t;
endpackage : tsc_pkg
`default_nettype wire

// *** tsc_stamp_clear.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_stamp_clear (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic strobe,
   output logic clearStamps,
   output logic clearFlag
);
   import tsc_pkg::*;
   tsc_clear_t state;
   tsc_clear_t next_state;

   always_comb begin
      next_state = state;
      next_state.pulse = strobe;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Registers and flag are cleared by the same pulse so they never disagree
   assign clearStamps = state.pulse;
   assign clearFlag = state.pulse;
endmodule : tsc_stamp_clear
`default_nettype wire

// *** tsc_control_reg.sv ***
// What this block does
// R1 - The control register can be read at any time, whether or not writes are locked.
// R2 - Writes to the control register are dropped while the password lock is active and taken otherwise.
// R3 - The control bits live at address 13h and are all zero after reset.
// R4 - A zero in the hot stamp reset bit clears nothing in the hot stamp group.
// R5 - Writing one to the hot stamp reset bit clears the seven hot stamp registers to 00h and the hot event flag.
// R6 - Writing one to the cold stamp reset bit clears the seven cold stamp registers to 00h.
// R7 - That same write also clears the cold event flag to zero.
// R8 - Writing one to the event stamp reset bit clears the event stamp registers to zero, and bits 7 and 6 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_cfg.svh"
module tsc_control_reg (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire tsc_pkg::tsc_req_t busReq,
   input wire logic writeLocked,
   output logic [7:0] rdData,
   output logic rdValid,
   output tsc_pkg::tsc_ow_t overwriteBits,
   output logic hotStampClear,
   output logic hotFlagClear,
   output logic coldStampClear,
   output logic coldFlagClear,
   output logic eventStampClear,
   output logic [7:0] stampClearValue
);
   import tsc_pkg::*;
   tsc_state_t state;
   tsc_state_t next_state;
   logic addrHit;
   logic writeTaken;
   logic hotStrobe;
   logic coldStrobe;
   logic eventStrobe;

   assign addrHit = (busReq.addr == `TSC_CTRL_ADDR); // see R3
   // Lock only gates writes; the read path never looks at it
   assign writeTaken = busReq.wrEn && addrHit && !writeLocked; // see R2
   assign hotStrobe = writeTaken && busReq.wrData[`TSC_BIT_HOT_RESET]; // see R4
   assign coldStrobe = writeTaken && busReq.wrData[`TSC_BIT_COLD_RESET];
   assign eventStrobe = writeTaken && busReq.wrData[`TSC_BIT_EVENT_RESET];

   always_comb begin
      next_state = state;
      next_state.rdValid = busReq.rdEn;
      next_state.rdData = 8'h00;
      if (busReq.rdEn && addrHit) begin // see R1
         // Reset strobes are not stored, so they always read back zero
         next_state.rdData[`TSC_BIT_EVENT_OW] = state.ow.eventOw;
         next_state.rdData[`TSC_BIT_HOT_OW] = state.ow.hotOw;
         next_state.rdData[`TSC_BIT_COLD_OW] = state.ow.coldOw; // see R8
      end
      // Reads sample state, not next_state, so a same-cycle write reads back old bits
      if (writeTaken) begin // see R2
         next_state.ow.eventOw = busReq.wrData[`TSC_BIT_EVENT_OW];
         next_state.ow.hotOw = busReq.wrData[`TSC_BIT_HOT_OW];
         next_state.ow.coldOw = busReq.wrData[`TSC_BIT_COLD_OW];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state.ow <= `TSC_OW_RESET; // see R3
         state.rdData <= `TSC_CTRL_RESET;
         state.rdValid <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign rdData = state.rdData;
   assign rdValid = state.rdValid;
   assign overwriteBits = state.ow;
   assign stampClearValue = `TSC_STAMP_CLEAR_VALUE; // see R5

   // Pulses are registered so each stamp group sees a clean one-cycle clear
   tsc_stamp_clear hotClr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .strobe(hotStrobe),
      .clearStamps(hotStampClear),
      .clearFlag(hotFlagClear)
   ); // see R5

   tsc_stamp_clear coldClr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .strobe(coldStrobe),
      .clearStamps(coldStampClear),
      .clearFlag(coldFlagClear)
   ); // see R6 R7

   // The event flag is left alone by this reset, so its flag pulse is unused
   tsc_stamp_clear eventClr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .strobe(eventStrobe),
      .clearStamps(eventStampClear),
      .clearFlag()
   ); // see R8

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence sOpenWrite;
      busReq.wrEn && busReq.addr == `TSC_CTRL_ADDR && !writeLocked;
   endsequence

   sequence sLockedWrite;
      busReq.wrEn && busReq.addr == `TSC_CTRL_ADDR && writeLocked;
   endsequence

   sequence sCtrlRead;
      busReq.rdEn && busReq.addr == `TSC_CTRL_ADDR;
   endsequence

   sequence sForeignRead;
      busReq.rdEn && busReq.addr != `TSC_CTRL_ADDR;
   endsequence

   sequence sForeignWrite;
      busReq.wrEn && busReq.addr != `TSC_CTRL_ADDR;
   endsequence

   // Each reset strobe is an unlocked write to this address with its bit set
   sequence sHotWrite;
      sOpenWrite ##0 busReq.wrData[`TSC_BIT_HOT_RESET];
   endsequence

   sequence sColdWrite;
      sOpenWrite ##0 busReq.wrData[`TSC_BIT_COLD_RESET];
   endsequence

   sequence sEventWrite;
      sOpenWrite ##0 busReq.wrData[`TSC_BIT_EVENT_RESET];
   endsequence

   a_read_always: assert property ( // see R1
      busReq.rdEn && busReq.addr == `TSC_CTRL_ADDR |=>
      rdValid && rdData[2:0] == $past(state.ow) && rdData[7:3] == 5'h00)
      else $error("control register read did not return its contents");

   a_locked_hold: assert property ( // see R2
      sLockedWrite |=> overwriteBits == $past(overwriteBits) &&
      !hotStampClear && !coldStampClear && !eventStampClear)
      else $error("locked write changed the control register");

   a_open_write: assert property ( // see R2
      sOpenWrite |=> overwriteBits == $past(busReq.wrData[2:0]))
      else $error("unlocked write was not stored");

   a_reset_zero: assert property (@(posedge core_clk) disable iff (1'b0) // see R3
      !rst_n |=> overwriteBits == 3'h0 && !hotStampClear && !coldStampClear &&
      !eventStampClear && rdData == 8'h00)
      else $error("control bits not zero after reset");

   a_hot_idle: assert property ( // see R4
      !(busReq.wrEn && busReq.addr == `TSC_CTRL_ADDR && !writeLocked &&
      busReq.wrData[`TSC_BIT_HOT_RESET]) |=> !hotStampClear && !hotFlagClear)
      else $error("hot group cleared without a reset write");

   a_hot_clear: assert property ( // see R5
      sHotWrite |=> hotStampClear && hotFlagClear &&
      stampClearValue == 8'h00)
      else $error("hot group not cleared by reset write");

   a_cold_clear: assert property ( // see R6
      sColdWrite |=> coldStampClear && stampClearValue == `TSC_STAMP_CLEAR_VALUE)
      else $error("cold stamp registers not cleared");

   a_cold_flag: assert property ( // see R7
      (coldStampClear |-> coldFlagClear) and (sOpenWrite ##0 busReq.wrData[3] |=> coldFlagClear))
      else $error("cold flag not cleared with its stamps");

   a_event_clear: assert property ( // see R8
      sEventWrite |=> eventStampClear ##1 (eventStampClear == $past(eventStrobe)))
      else $error("event stamp registers not cleared");

   a_top_zero: assert property ( // see R8
      rdValid |-> rdData[7:3] == 5'h00)
      else $error("reserved or strobe bits read nonzero");

   // Refused, foreign and idle traffic must leave the bits and the pulses alone
   a_foreign_write: assert property ( // see R3
      sForeignWrite |=> overwriteBits == $past(overwriteBits) &&
      !hotStampClear && !coldStampClear && !eventStampClear)
      else $error("write to another address changed the control register");

   a_ow_steady: assert property ( // see R2
      !(busReq.wrEn && busReq.addr == `TSC_CTRL_ADDR && !writeLocked) |=>
      overwriteBits == $past(overwriteBits))
      else $error("overwrite bits moved without a taken write");

   a_cold_idle: assert property ( // see R6
      !(busReq.wrEn && busReq.addr == `TSC_CTRL_ADDR && !writeLocked &&
      busReq.wrData[`TSC_BIT_COLD_RESET]) |=> !coldStampClear && !coldFlagClear)
      else $error("cold group cleared without a reset write");

   a_event_idle: assert property ( // see R8
      !(busReq.wrEn && busReq.addr == `TSC_CTRL_ADDR && !writeLocked &&
      busReq.wrData[`TSC_BIT_EVENT_RESET]) |=> !eventStampClear)
      else $error("event group cleared without a reset write");

   a_event_once: assert property ( // see R8
      sEventWrite ##1 !busReq.wrEn |=> !eventStampClear)
      else $error("event clear pulse lasted more than one cycle");

   a_read_locked: assert property ( // see R1
      sCtrlRead ##0 writeLocked |=> rdValid && rdData[2:0] == $past(overwriteBits))
      else $error("control register not readable while locked");

   a_read_other: assert property ( // see R3
      sForeignRead |=> rdValid && rdData == 8'h00)
      else $error("another address read back control bits");

   a_no_read: assert property ( // see R1
      !busReq.rdEn |=> !rdValid && rdData == 8'h00)
      else $error("read data shown without a read");

   // Write, one quiet cycle, then read: the read must return what was written
   a_write_readback: assert property ( // see R3
      sOpenWrite ##1 !busReq.wrEn ##1 sCtrlRead |=>
      rdData[2:0] == $past(busReq.wrData[2:0], 3) && rdData[7:6] == 2'h0)
      else $error("written overwrite bits did not read back");
endmodule : tsc_control_reg
`default_nettype wire

// *** tsc_control_reg_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tsc_cfg.svh"
module tsc_control_reg_test;
   import tsc_pkg::*;
   typedef struct packed {
      logic lock;
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] rd;
      logic [4:0] pul;
   } tsc_row_t;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   tsc_req_t busReq = '0;
   logic writeLocked = 1'b0;
   logic [7:0] rdData;
   logic rdValid;
   tsc_ow_t overwriteBits;
   logic hotStampClear, hotFlagClear, coldStampClear, coldFlagClear, eventStampClear;
   logic [7:0] stampClearValue;
   logic [4:0] pulses;
   int nMismatch = 0;
   int compares = 0;
   int cycles = 0;
   // Locked and foreign-address rows use data that would fire every strobe if taken
   tsc_row_t rows [8] = '{'{1'b0, 8'h13, 8'h12, 8'h02, 5'h18}, '{1'b0, 8'h13, 8'h08, 8'h00, 5'h06},
      '{1'b0, 8'h13, 8'h20, 8'h00, 5'h01}, '{1'b0, 8'h13, 8'hC7, 8'h07, 5'h00},
      '{1'b1, 8'h13, 8'h3F, 8'h07, 5'h00}, '{1'b0, 8'h14, 8'h3F, 8'h07, 5'h00},
      '{1'b0, 8'h13, 8'h3F, 8'h07, 5'h1F}, '{1'b0, 8'h13, 8'h00, 8'h00, 5'h00}};
   assign pulses = {hotStampClear, hotFlagClear, coldStampClear, coldFlagClear, eventStampClear};
   tsc_control_reg uut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .busReq(busReq),
      .writeLocked(writeLocked),
      .rdData(rdData),
      .rdValid(rdValid),
      .overwriteBits(overwriteBits),
      .hotStampClear(hotStampClear),
      .hotFlagClear(hotFlagClear),
      .coldStampClear(coldStampClear),
      .coldFlagClear(coldFlagClear),
      .eventStampClear(eventStampClear),
      .stampClearValue(stampClearValue)
   );
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         nMismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic access(input logic rdEn, input logic wrEn, input logic [7:0] a,
         input logic [7:0] d);
      @(posedge core_clk);
      #1 busReq = '{rdEn, wrEn, a, d};
      @(posedge core_clk);
      #1 busReq = '0;
   endtask : access
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, nMismatch);
      if (nMismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         nMismatch++;
         wrap_up();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      #1 chk({pulses, overwriteBits}, 8'h00);
      chk({rdValid, rdData}, 16'h0000);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         writeLocked = rows[i].lock;
         access(1'b0, 1'b1, rows[i].addr, rows[i].data);
         chk({3'h0, pulses}, {3'h0, rows[i].pul});
         access(1'b1, 1'b0, `TSC_CTRL_ADDR, 8'h00);
         chk({rdValid, rdData}, {1'b1, rows[i].rd});
         chk({3'h0, pulses}, 8'h00);
         chk({5'h0, overwriteBits}, {5'h0, rows[i].rd[2:0]});
      end
      chk(stampClearValue, 8'h00);
      // A read taken with a write in the same cycle still returns the old contents
      access(1'b1, 1'b1, `TSC_CTRL_ADDR, 8'h02);
      chk({rdValid, rdData}, {1'b1, 8'h00});
      // Another address reads zero even though the control bits are now nonzero
      access(1'b1, 1'b0, 8'h14, 8'h00);
      chk({rdValid, rdData}, {1'b1, 8'h00});
      access(1'b1, 1'b0, `TSC_CTRL_ADDR, 8'h00);
      chk(rdData, 8'h02);
      // Back-to-back writes: each pulse lasts one cycle and the second write lands
      @(posedge core_clk);
      #1 busReq = '{1'b0, 1'b1, `TSC_CTRL_ADDR, 8'h11};
      @(posedge core_clk);
      #1 busReq = '{1'b0, 1'b1, `TSC_CTRL_ADDR, 8'h0A};
      chk({3'h0, pulses}, 8'h18);
      chk({5'h0, overwriteBits}, 8'h01);
      @(posedge core_clk);
      #1 busReq = '0;
      chk({3'h0, pulses}, 8'h06);
      chk({5'h0, overwriteBits}, 8'h02);
      @(posedge core_clk);
      #1 rst_n = 1'b0;
      @(posedge core_clk);
      #1 rst_n = 1'b1;
      chk({5'h0, overwriteBits}, 8'h00);
      chk({rdValid, rdData, pulses}, 16'h0000);
      wrap_up();
   end
endmodule : tsc_control_reg_test
`default_nettype wire
